// [tmr_status_flags.sv]
// device end: cycle-match and one-shot status flag registers
// assumes event inputs are single-cycle pulses on i_mclk
`timescale 1ns/1ns
`include "tmr_status_defines.svh"
module tmr_status_flags
(
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst_n,
  tmr_status_if.dev                        bus,
  input  wire tmr_status_pkg::cycle_flags_t i_cycle_match,
  input  wire tmr_status_pkg::status_byte_t i_underflow,
  input  wire logic                        i_dma_src_en,
  input  wire logic                        i_dma_done,
  output tmr_status_pkg::status_byte_t     o_cycle_match_status,
  output tmr_status_pkg::status_byte_t     o_oneshot_underflow_status
);
  import tmr_status_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // strobes decoded once and shared by every flag cell of the register they select
  logic              cyc_rd;
  logic              cyc_wr;
  logic              os_rd;
  logic              os_wr;
  cycle_flags_t      cyc_zero_wr;
  cycle_flags_t      cyc_dma;
  status_byte_t      os_zero_wr;
  // each bit of these nets is driven by its own cell
  wire cycle_flags_t cyc_q;
  wire cycle_flags_t cyc_d;
  wire status_byte_t os_q;
  wire status_byte_t os_d;
  status_byte_t      rdata_q;
  status_byte_t      rdata_d;
  logic              ack_q;
  logic              ack_d;
  status_byte_t      cyc_view_d;
  status_byte_t      os_view_d;

  //////////////////////////////////////////////////////////////////////////////
  function automatic status_byte_t pack_cycle(input cycle_flags_t f);
    status_byte_t v;
    v              = `BYTE_ZERO;  // odd bits stay zero
    v[`CH6_BIT]    = f[`CH6_IDX];
    v[`CH7_BIT]    = f[`CH7_IDX];
    v[`CH8_BIT]    = f[`CH8_IDX];
    v[`CH9_BIT]    = f[`CH9_IDX];
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    cyc_rd                = bus.rd && (bus.sel == `SEL_CYCLE);
    cyc_wr                = bus.wr && (bus.sel == `SEL_CYCLE);
    os_rd                 = bus.rd && (bus.sel == `SEL_ONESHOT);
    os_wr                 = bus.wr && (bus.sel == `SEL_ONESHOT);
    // ones never reach a clear term
    cyc_zero_wr[`CH6_IDX] = ~bus.wdata[`CH6_BIT];
    cyc_zero_wr[`CH7_IDX] = ~bus.wdata[`CH7_BIT];
    cyc_zero_wr[`CH8_IDX] = ~bus.wdata[`CH8_BIT];
    cyc_zero_wr[`CH9_IDX] = ~bus.wdata[`CH9_BIT];
    os_zero_wr            = ~bus.wdata;
    cyc_dma               = `CYCLE_RESET;
    // only ch6 can be a dma source, so only ch6 has this path
    cyc_dma[`CH6_IDX]     = i_dma_src_en & i_dma_done;
  end

  //////////////////////////////////////////////////////////////////////////////
  // cycle-match cells: a read arms what it saw, the next write may clear it
  for (genvar gi = 0; gi < $bits(cycle_flags_t); gi++)
  begin : g_cycle
    logic flag_q;
    logic flag_d;
    logic arm_q;
    logic arm_d;
    logic clr;

    always_comb
    begin
      clr   = (cyc_wr & arm_q & cyc_zero_wr[gi]) | cyc_dma[gi];
      arm_d = arm_q;
      if (cyc_rd)
      begin
        arm_d = arm_q | flag_q;
      end
      // any cycle-register write disarms, so a stale read cannot clear a later event
      if (cyc_wr || clr)
      begin
        arm_d = `FLAG_RESET;
      end
      // set wins over clear so a fresh match is never lost
      flag_d = (flag_q & ~clr) | i_cycle_match[gi];
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        flag_q <= `FLAG_RESET;
        arm_q  <= `FLAG_RESET;
      end
      else
      begin
        flag_q <= flag_d;
        arm_q  <= arm_d;
      end
    end

    assign cyc_q[gi] = flag_q;
    assign cyc_d[gi] = flag_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one-shot cells: bit i follows down-counter i, a=0 .. h=7
  for (genvar gi = 0; gi < $bits(status_byte_t); gi++)
  begin : g_oneshot
    logic flag_q;
    logic flag_d;
    logic arm_q;
    logic arm_d;
    logic clr;

    always_comb
    begin
      clr   = os_wr & arm_q & os_zero_wr[gi];
      arm_d = arm_q;
      if (os_rd)
      begin
        arm_d = arm_q | flag_q;
      end
      // no dma path here, only software clears these
      if (os_wr)
      begin
        arm_d = `FLAG_RESET;
      end
      // set wins over clear
      flag_d = (flag_q & ~clr) | i_underflow[gi];
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        flag_q <= `FLAG_RESET;
        arm_q  <= `FLAG_RESET;
      end
      else
      begin
        flag_q <= flag_d;
        arm_q  <= arm_d;
      end
    end

    assign os_q[gi] = flag_q;
    assign os_d[gi] = flag_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data holds until the next read
  always_comb
  begin
    rdata_d = rdata_q;
    ack_d   = bus.rd | bus.wr;
    if (cyc_rd)
    begin
      rdata_d = pack_cycle(cyc_q);
    end
    else if (os_rd)
    begin
      rdata_d = os_q;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_q <= `BYTE_ZERO;
      ack_q   <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs register the next state, so they match the flags cycle for cycle
  always_comb
  begin
    cyc_view_d = pack_cycle(cyc_d);
    os_view_d  = os_d;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_cycle_match_status       <= `BYTE_ZERO;
      o_oneshot_underflow_status <= `BYTE_ZERO;
    end
    else
    begin
      o_cycle_match_status       <= cyc_view_d;
      o_oneshot_underflow_status <= os_view_d;
    end
  end

  assign bus.rdata = rdata_q;
  assign bus.ack   = ack_q;
endmodule

// [tmr_status_defines.svh]
// constants for the timer status flag bank and its controller
// assumes inclusion by bare name from both ends and the testbench
`ifndef TMR_STATUS_DEFINES_SVH
`define TMR_STATUS_DEFINES_SVH

// register select on the device port
`define SEL_CYCLE          1'b0
`define SEL_ONESHOT        1'b1

// cycle-match bit positions in the 8-bit view
`define CH6_BIT            6
`define CH7_BIT            4
`define CH8_BIT            2
`define CH9_BIT            0
// index of each channel in the 4-bit flag store
`define CH6_IDX            3
`define CH7_IDX            2
`define CH8_IDX            1
`define CH9_IDX            0
`define CYCLE_LIVE_MASK    8'h55

`define CYCLE_RESET        4'h0
`define ONESHOT_RESET      8'h00
`define BYTE_ZERO          8'h00
`define FLAG_RESET         1'b0

// controller wishbone map (byte addresses)
`define WB_CMD_ADDR        4'h0
`define WB_STATUS_ADDR     4'h4
`define CMD_SEL_BIT        8
`define CMD_WR_BIT         9
`define STAT_BUSY_BIT      0
`define STAT_DATA_MSB      15
`define STAT_DATA_LSB      8
`define CMD_DATA_MSB       7
`define CMD_DATA_LSB       0
`define CMD_LANE_BIT       1
`define WORD_ZERO          32'h0000_0000

`endif

// [tmr_status_pkg.sv]
// types shared by the status flag bank and its controller
// assumes the defines header is on the include path
package tmr_status_pkg;
  typedef logic [7:0] status_byte_t;
  typedef logic [3:0] cycle_flags_t;
  typedef enum logic {CTRL_IDLE, CTRL_WAIT} ctrl_state_t;
endpackage

// [tmr_status_if.sv]
// register port between the flag bank and its controller
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface tmr_status_if;
  import tmr_status_pkg::*;
  logic         sel;
  logic         rd;
  logic         wr;
  status_byte_t wdata;
  status_byte_t rdata;
  logic         ack;

  modport dev  (input sel, input rd, input wr, input wdata, output rdata, output ack);
  modport host (output sel, output rd, output wr, output wdata, input rdata, input ack);
endinterface

// [tmr_status_ctrl.sv]
// controller end: wishbone classic slave issuing flag reads and writes
// assumes the flag bank answers with ack one cycle after each strobe
`timescale 1ns/1ns
`include "tmr_status_defines.svh"
module tmr_status_ctrl
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  tmr_status_if.host       bus,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack
);
  import tmr_status_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  ctrl_state_t  state_q;
  ctrl_state_t  state_d;
  logic         sel_q;
  logic         sel_d;
  logic         rd_q;
  logic         rd_d;
  logic         wr_q;
  logic         wr_d;
  logic         op_wr_q;
  logic         op_wr_d;
  status_byte_t wdata_q;
  status_byte_t wdata_d;
  status_byte_t rdata_q;
  status_byte_t rdata_d;
  logic [31:0]  dat_d;
  logic         ack_d;
  logic         wb_hit;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    wb_hit  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    ack_d   = wb_hit;
    dat_d   = `WORD_ZERO;
    state_d = state_q;
    sel_d   = sel_q;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    op_wr_d = op_wr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    if (wb_hit && !i_wb_we && i_wb_adr == `WB_STATUS_ADDR)
    begin
      dat_d[`STAT_DATA_MSB:`STAT_DATA_LSB] = rdata_q;
      dat_d[`STAT_BUSY_BIT] = (state_q == CTRL_WAIT);
    end
    else if (wb_hit && !i_wb_we && i_wb_adr == `WB_CMD_ADDR)
    begin
      dat_d[`CMD_DATA_MSB:`CMD_DATA_LSB] = wdata_q;
      dat_d[`CMD_SEL_BIT] = sel_q;
      dat_d[`CMD_WR_BIT]  = op_wr_q;
    end
    case (state_q)
      CTRL_IDLE:
      begin
        // commands while busy are dropped, software polls busy first
        if (wb_hit && i_wb_we && i_wb_adr == `WB_CMD_ADDR && i_wb_sel[`CMD_LANE_BIT])
        begin
          state_d = CTRL_WAIT;
          sel_d   = i_wb_dat[`CMD_SEL_BIT];
          op_wr_d = i_wb_dat[`CMD_WR_BIT];
          rd_d    = ~i_wb_dat[`CMD_WR_BIT];
          wr_d    = i_wb_dat[`CMD_WR_BIT];
          wdata_d = i_wb_dat[`CMD_DATA_MSB:`CMD_DATA_LSB];
          if (i_wb_dat[`CMD_SEL_BIT] == `SEL_CYCLE)
          begin
            // reserved written as 0
            wdata_d = i_wb_dat[`CMD_DATA_MSB:`CMD_DATA_LSB] & `CYCLE_LIVE_MASK;
          end
        end
      end
      CTRL_WAIT:
      begin
        if (bus.ack)
        begin
          state_d = CTRL_IDLE;
          if (!op_wr_q)
          begin
            rdata_d = bus.rdata;
          end
        end
      end
      default:
      begin
        state_d = CTRL_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q  <= CTRL_IDLE;
      sel_q    <= `SEL_CYCLE;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      op_wr_q  <= 1'b0;
      wdata_q  <= `BYTE_ZERO;
      rdata_q  <= `BYTE_ZERO;
      o_wb_dat <= `WORD_ZERO;
      o_wb_ack <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      sel_q    <= sel_d;
      rd_q     <= rd_d;
      wr_q     <= wr_d;
      op_wr_q  <= op_wr_d;
      wdata_q  <= wdata_d;
      rdata_q  <= rdata_d;
      o_wb_dat <= dat_d;
      o_wb_ack <= ack_d;
    end
  end

  assign bus.sel   = sel_q;
  assign bus.rd    = rd_q;
  assign bus.wr    = wr_q;
  assign bus.wdata = wdata_q;
endmodule

// [tmr_status_sva.sv]
// checker for the flag bank port and the two status outputs
// assumes instantiation beside the interface, one clock domain
`timescale 1ns/1ns
module tmr_status_sva
(
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic       sel,
  input wire logic       rd,
  input wire logic       wr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ack,
  input wire logic [3:0] i_cycle_match,
  input wire logic [7:0] i_underflow,
  input wire logic       i_dma_src_en,
  input wire logic       i_dma_done,
  input wire logic [7:0] o_cycle_match_status,
  input wire logic [7:0] o_oneshot_underflow_status
);
  logic [7:0] cm;
  logic [7:0] os;
  logic [7:0] sp;
  assign cm = o_cycle_match_status;
  assign os = o_oneshot_underflow_status;
  assign sp = {1'b0, i_cycle_match[3], 1'b0, i_cycle_match[2],
               1'b0, i_cycle_match[1], 1'b0, i_cycle_match[0]};
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_cm_read;
    rd && !sel ##1 ack;
  endsequence
  sequence s_os_read;
    rd && sel && (i_underflow == 8'h00) ##1 ack;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_cm_set: assert property (1 |=> ((cm & $past(sp)) == $past(sp)))
    else $error("cycle flag missed its event");
  a_os_set: assert property (1 |=> ((os & $past(i_underflow)) == $past(i_underflow)))
    else $error("one-shot flag missed its event");
  a_cm_resv: assert property ((cm & 8'hAA) == 8'h00)
    else $error("reserved cycle bit set");
  a_cm_rise: assert property ((cm & ~$past(cm) & ~$past(sp)) == 8'h00)
    else $error("cycle flag rose without event");
  a_os_rise: assert property ((os & ~$past(os) & ~$past(i_underflow)) == 8'h00)
    else $error("one-shot flag rose without event");
  a_os_fall: assert property ((($past(os) & ~os) != 8'h00) |->
    ($past(wr) && $past(sel) && (($past(os) & ~os & $past(wdata)) == 8'h00)))
    else $error("one-shot flag fell without zero write");
  a_cm_fall: assert property ((($past(cm) & ~cm) != 8'h00) |->
    ($past(wr) && !$past(sel) && (($past(cm) & ~cm & $past(wdata)) == 8'h00)) ||
    ($past(i_dma_src_en) && $past(i_dma_done) && (($past(cm) & ~cm) == 8'h40)))
    else $error("cycle flag fell without clearing cause");
  a_dma_clr: assert property (i_dma_src_en && i_dma_done && !i_cycle_match[3] |=> !cm[6])
    else $error("dma done left ch6 flag set");
  a_cm_rdata: assert property (s_cm_read |-> ((rdata & 8'hAA) == 8'h00))
    else $error("reserved bit read as one");
  a_os_rdata: assert property (s_os_read |-> (rdata == $past(os)))
    else $error("one-shot read data wrong");
endmodule

// [testbench.sv]
// self-checking bench: wishbone into controller, controller into flag bank
// assumes package, interface, both ends and checker compiled first
`timescale 1ns/1ns
`include "tmr_status_defines.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  import tmr_status_pkg::*;
  logic         i_mclk, i_rst_n, cyc, stb, we, en, dn, s, ack;
  logic [3:0]   adr;
  cycle_flags_t cm;
  status_byte_t uf, r, cm8, os8;
  status_byte_t m [2];
  status_byte_t arm [2];
  logic [31:0]  dat, q, rdat;
  integer       fail_count = 0, n_checks = 0, seed = 32'h255a, k;
  tmr_status_if bus_if ();
  tmr_status_flags tmr_status_flags_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(bus_if),
    .i_cycle_match(cm), .i_underflow(uf), .i_dma_src_en(en), .i_dma_done(dn),
    .o_cycle_match_status(cm8), .o_oneshot_underflow_status(os8));
  tmr_status_ctrl tmr_status_ctrl_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(bus_if),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat),
    .i_wb_sel(4'hF), .o_wb_dat(rdat), .o_wb_ack(ack));
  tmr_status_sva tmr_status_sva_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .sel(bus_if.sel),
    .rd(bus_if.rd), .wr(bus_if.wr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
    .ack(bus_if.ack), .i_cycle_match(cm), .i_underflow(uf), .i_dma_src_en(en),
    .i_dma_done(dn), .o_cycle_match_status(cm8), .o_oneshot_underflow_status(os8));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // ack and read data are taken at the rising edge that shows ack high
    do @(posedge i_mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // busy is polled since a new command while busy is dropped silently
  task automatic op(input logic w, input status_byte_t d);
    wb(1'b1, `WB_CMD_ADDR, {22'h0, w, s, d});
    q = 32'h1;
    while (q[`STAT_BUSY_BIT] !== 1'b0)
      wb(1'b0, `WB_STATUS_ADDR, 32'h0);
    r = q[15:8];
  endtask
  task automatic chk;
    op(1'b0, 8'h00);
    arm[s] = m[s];
    `CHK("read", m[s], r)
    `CHK("flags", m[s], s ? os8 : cm8)
  endtask
  task automatic clr(input status_byte_t d);
    op(1'b1, d);
    wb(1'b0, `WB_CMD_ADDR, 32'h0);
    `CHK("command", {22'h0, 1'b1, s, d & (s ? 8'hFF : `CYCLE_LIVE_MASK)}, q)
    m[s] = m[s] & ~(arm[s] & ~d);
    arm[s] = 8'h00;
  endtask
  task automatic ev(input status_byte_t v);
    @(posedge i_mclk);
    if (s)
      uf <= v;
    else
      cm <= {v[6], v[4], v[2], v[0]};
    @(posedge i_mclk);
    uf <= 8'h00;
    cm <= 4'h0;
    m[s] = m[s] | (s ? v : v & `CYCLE_LIVE_MASK);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  initial
  begin
    #200000;
    fail_count++;
    stop_test();
  end
  initial
  begin
    {i_rst_n, cyc, stb, we, en, dn, s} = 7'h0;
    {adr, cm, uf, dat} = 48'h0;
    m = '{8'h00, 8'h00};
    arm = '{8'h00, 8'h00};
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      s = k[3];
      ev(8'h01 << k[2:0]);
      clr(8'h00);
      chk();
      clr(8'hFF);
      chk();
      clr(8'h00);
      chk();
    end
    s = 1'b0;
    ev(8'h40);
    @(posedge i_mclk);
    dn <= 1'b1;
    @(posedge i_mclk);
    dn <= 1'b0;
    chk();
    en <= 1'b1;
    dn <= 1'b1;
    @(posedge i_mclk);
    dn <= 1'b0;
    en <= 1'b0;
    m[0] = 8'h00;
    arm[0] = arm[0] & ~8'h40;
    chk();
    // random events with random partial clears, then a reset in mid-run
    for (k = 0; k < 40; k++)
    begin
      s = 1'($random(seed));
      ev(8'($random(seed)));
      if (k % 3)
        chk();
      clr(8'($random(seed) & $random(seed)));
      chk();
    end
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    m = '{8'h00, 8'h00};
    arm = '{8'h00, 8'h00};
    s = 1'b0;
    chk();
    s = 1'b1;
    chk();
    stop_test();
  end
endmodule
